// ==== src/hpc_reg.sv ====
// hard power-on configuration register with plain register port
`timescale 1ns/1ps
module hpc_reg
  import hpc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [hpc_pkg::ADDR_W-1:0] addr,
  input wire logic [hpc_pkg::DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire hpc_pkg::hpc_strap_s strap_pin,
  input wire logic [hpc_pkg::LOW_W-1:0] low_bits,
  output logic [hpc_pkg::DATA_W-1:0] rdata,
  output logic [hpc_pkg::LOW_W-1:0] low_wr_data,
  output logic low_wr
);
  hpc_strap_s strap_q;
  hpc_req_s req;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] image;
  logic [LOW_W-1:0] low_d;
  logic low_wr_d;

  ////////////////////////////////////////////////////////////////
  hpc_strap_cap u_cap
  (
    .clock(clock),
    .srst(srst),
    .strap_pin(strap_pin),
    .strap_q(strap_q)
  );

  function automatic logic hit(input logic [ADDR_W-1:0] a);
    hit = (a == HPC_ADDR);
  endfunction

  ////////////////////////////////////////////////////////////////
  always_comb
  begin
    req.wr = wr_stb;
    req.rd = rd_stb;
    req.addr = addr;
    req.wdata = wdata;
    // everything not assigned stays zero: reserved and tied fields
    image = '0;
    image[BIT_BUS_ERROR_SIGNAL_EN] = 1'b0;
    image[BIT_BUS_INITIALIZATION_SIGNAL_DRV_EN] = 1'b0;
    image[BIT_SELF_TEST] = strap_q.self_test;
    image[BIT_VEC_1MB] = strap_q.vec_1mb;
    image[RATIO_LO +: RATIO_W] = strap_q.bus_ratio;
    image[LOW_W-1:0] = low_bits;
    rdata_d = RDATA_RESET;
    if (req.rd && hit(req.addr))
    begin
      rdata_d = image;
    end
    // only bits 3:0 pass on; the tied enables are dropped on write
    low_d = req.wdata[LOW_W-1:0];
    low_wr_d = req.wr && hit(req.addr);
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rdata <= RDATA_RESET;
      low_wr_data <= LOW_RESET;
      low_wr <= 1'b0;
    end
    else
    begin
      rdata <= rdata_d;
      low_wr_data <= low_d;
      low_wr <= low_wr_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  AST_TIED_ZERO: assert property (@(posedge clock) disable iff (srst)
    $past(rd_stb) && $past(addr) == HPC_ADDR |->
    rdata[BIT_BUS_ERROR_SIGNAL_EN] == 1'b0 && rdata[BIT_BUS_INITIALIZATION_SIGNAL_DRV_EN] == 1'b0
    && rdata[BIT_ADDRESS_ERROR_SIGNAL_OBS] == 1'b0 && rdata[BIT_BUS_INITIALIZATION_SIGNAL_OBS] == 1'b0)
    else $error("tied enable bit read as one");
  AST_IDS_ZERO: assert property (@(posedge clock) disable iff (srst)
    rdata[CLUSTER_LO +: 2] == 2'h0 && rdata[ARB_LO +: 2] == 2'h0)
    else $error("identifier field not zero");
  AST_RESERVED: assert property (@(posedge clock) disable iff (srst)
    rdata[63:27] == 37'h0 && rdata[19:18] == 2'h0 && rdata[15] == 1'b0
    && rdata[13] == 1'b0 && rdata[11] == 1'b0 && rdata[8] == 1'b0
    && rdata[6:5] == 2'h0)
    else $error("reserved bit read as one");
  AST_RATIO: assert property (@(posedge clock) disable iff (srst)
    rd_stb && addr == HPC_ADDR |=>
    rdata[RATIO_LO +: RATIO_W] == $past(strap_q.bus_ratio))
    else $error("bus ratio mismatch");
  AST_SELF_TEST: assert property (@(posedge clock) disable iff (srst)
    rd_stb && addr == HPC_ADDR |=>
    rdata[BIT_SELF_TEST] == $past(strap_q.self_test)
    && rdata[BIT_VEC_1MB] == $past(strap_q.vec_1mb))
    else $error("strap bit mismatch");
  AST_MISS: assert property (@(posedge clock) disable iff (srst)
    !(rd_stb && addr == HPC_ADDR) |=> rdata == 64'h0)
    else $error("data without hit read");
  AST_WR_STABLE: assert property (@(posedge clock) disable iff (srst)
    wr_stb && !$past(srst) |=> $stable(strap_q))
    else $error("write changed captured config");
  AST_LOW_WR: assert property (@(posedge clock) disable iff (srst)
    wr_stb && addr == HPC_ADDR |=> low_wr && low_wr_data == $past(wdata[3:0]))
    else $error("low enable write lost");
endmodule

// ==== shared/hpc_pkg.sv ====
// package for the hard power-on configuration register block
package hpc_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 64;
  localparam logic [ADDR_W-1:0] HPC_ADDR = 12'h02a;
  localparam int unsigned BIT_BUS_ERROR_SIGNAL_EN = 4;
  localparam int unsigned BIT_BUS_INITIALIZATION_SIGNAL_DRV_EN = 7;
  localparam int unsigned BIT_SELF_TEST = 9;
  localparam int unsigned BIT_ADDRESS_ERROR_SIGNAL_OBS = 10;
  localparam int unsigned BIT_BUS_INITIALIZATION_SIGNAL_OBS = 12;
  localparam int unsigned BIT_VEC_1MB = 14;
  localparam int unsigned CLUSTER_LO = 16;
  localparam int unsigned ARB_LO = 20;
  localparam int unsigned RATIO_LO = 22;
  localparam int unsigned RATIO_W = 5;
  localparam int unsigned LOW_W = 4;
  localparam logic [LOW_W-1:0] LOW_RESET = 4'h0;
  localparam logic [DATA_W-1:0] RDATA_RESET = 64'h0;

  typedef struct packed {
    logic self_test;
    logic vec_1mb;
    logic [RATIO_W-1:0] bus_ratio;
  } hpc_strap_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } hpc_req_s;
endpackage

// ==== src/hpc_strap_cap.sv ====
// captures the power-on strap levels after two-stage synchronisation
`timescale 1ns/1ps
module hpc_strap_cap
  import hpc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire hpc_pkg::hpc_strap_s strap_pin,
  output hpc_pkg::hpc_strap_s strap_q
);
  hpc_strap_s meta_q;
  hpc_strap_s sync_q;
  hpc_strap_s strap_d;
  logic taken_q;
  logic taken_d;

  // take the synchronised straps once, on the first cycle after reset
  always_comb
  begin
    strap_d = strap_q;
    taken_d = 1'b1;
    if (!taken_q)
    begin
      strap_d = sync_q;
    end
  end

  always_ff @(posedge clock)
  begin
    meta_q <= strap_pin;
    sync_q <= meta_q;
    if (srst)
    begin
      taken_q <= 1'b0;
      strap_q <= '0;
    end
    else
    begin
      taken_q <= taken_d;
      strap_q <= strap_d;
    end
  end
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the hard power-on configuration register
`timescale 1ns/1ps
module tb;
  import hpc_pkg::*;
  localparam hpc_strap_s S0 = '{1'b1, 1'b0, 5'h15};
  localparam hpc_strap_s S1 = '{1'b0, 1'b1, 5'h0a};
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] addr = 12'h000;
  logic [DATA_W-1:0] wdata = 64'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  hpc_strap_s strap_pin = S0;
  logic [LOW_W-1:0] low_bits = 4'ha;
  logic [DATA_W-1:0] rdata;
  logic [LOW_W-1:0] low_wr_data;
  logic low_wr;
  int err_count = 0;
  int num_checks = 0;
  always #2.5 clock = ~clock;
  hpc_reg DUT (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .strap_pin(strap_pin),
    .low_bits(low_bits), .rdata(rdata), .low_wr_data(low_wr_data),
    .low_wr(low_wr));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [63:0] img(hpc_strap_s s, logic [3:0] lb);
    logic [63:0] v;
    v = 64'h0;
    v[3:0] = lb;
    v[BIT_SELF_TEST] = s.self_test;
    v[BIT_VEC_1MB] = s.vec_1mb;
    v[RATIO_LO +: RATIO_W] = s.bus_ratio;
    return v;
  endfunction
  task automatic rd(logic [11:0] a, logic [63:0] exp);
    @(posedge clock);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1;
    chk("rdata", rdata, exp);
  endtask
  task automatic wr(logic [11:0] a, logic [63:0] d, logic hit);
    @(posedge clock);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr_stb <= 1'b0;
    #1;
    chk("low_wr", {63'h0, low_wr}, {63'h0, hit});
    if (hit)
      chk("low_wr_data", {60'h0, low_wr_data}, {60'h0, d[3:0]});
  endtask
  task automatic do_reset;
    srst <= 1'b1;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    // straps were taken from the two-flop sync on the first edge after release
    repeat (3) @(posedge clock);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    do_reset();
    chk("rdata idle", rdata, 64'h0);
    rd(HPC_ADDR, img(S0, 4'ha));
    @(posedge clock);
    #1;
    chk("rdata after", rdata, 64'h0);
    $display("test 1 done");
    wr(HPC_ADDR, 64'hffff_ffff_ffff_ffff, 1'b1);
    rd(HPC_ADDR, img(S0, 4'ha));
    wr(HPC_ADDR, 64'h0, 1'b1);
    low_bits <= 4'h5;
    rd(HPC_ADDR, img(S0, 4'h5));
    $display("test 2 done");
    rd(12'h02b, 64'h0);
    rd(12'h12a, 64'h0);
    wr(12'h02b, 64'hffff_ffff_ffff_ffff, 1'b0);
    $display("test 3 done");
    strap_pin <= S1;
    repeat (4) @(posedge clock);
    rd(HPC_ADDR, img(S0, 4'h5));
    do_reset();
    rd(HPC_ADDR, img(S1, 4'h5));
    $display("test 4 done");
    end_sim();
  end
  // tests take about 41 cycles; allow ample margin
  initial
  begin
    #5000;
    err_count++;
    end_sim();
  end
endmodule
